// ==== hw/ulpib_phy.sv ====
// What this block does
// [R1] all link outputs come from flops on the rising link clock
// [R2] bus moves one byte per rising edge; phy drives only while dir is high
// [R3] phy raises dir from idle when it has receive data or register data
// [R4] with nothing to send, dir low and link commands are watched
// [R5] dir held high while the phy cannot accept, e.g. pll start-up
// [R6] the link takes bus direction only from dir
// [R7] a nonzero bus byte with top bits other than 00 starts a transfer; zero means idle
// [R8] one turnaround cycle after each dir change; bus ignored then
// [R9] link ends a stream with stp for exactly one cycle
// [R10] stp during transmit marks previous byte as the last one
// [R11] nxt marks the cycle a transmit byte is accepted; withheld throttles
// [R12] after nxt the link shows the next byte in the following cycle
// [R13] stp is used for start-up and to resume from suspend; start-up here waits on pll_ready, then startup_cycles link clocks, and ignores stp
// [R14] low power: clock stopped, bus bits 1:0 carry line state; here line state goes out through link_clk flops
// [R15] low power: async interrupt when otg comparators or id change; here lp_interrupt comes from mclk flops
// [R16] receive end latency at most 43 hs clocks, below 63
// [R17] one decoder steers link traffic to transmitter or registers
// [R18] every register reached over the bus is 8 bits wide
// [R19] link releases the bus in the cycle dir rises
module ulpib_phy (
  // core clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link interface clock domain
  input wire logic link_clk,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic dir,
  output logic nxt,
  input wire logic stp,
  // phy core side
  input wire logic pll_ready,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  // low power mode
  input wire logic suspend,
  input wire logic [1:0] line_state,
  input wire logic [2:0] otg_comp,
  input wire logic id_pin,
  output logic lp_interrupt,
  output logic resume_req
);

  typedef struct packed {
    ulpib_pkg::ulpib_state_t st;
    logic [7:0] cnt;
    logic [5:0] addr;
    logic [7:0] dout;
    logic oe;
    logic dir;
    logic nxt;
    logic [7:0] txd;
    logic txv;
    logic txl;
    logic [7:0] rxd;
    logic rxv;
    logic rxe;
    logic [2:0] sync_stp;
    logic [2:0] sync_pll;
    logic [2:0] sync_txr;
    logic [2:0] sync_susp;
    // line state passes three flops into the link domain
    logic [1:0] ls1;
    logic [1:0] ls2;
    logic [1:0] ls3;
  } ulpib_link_state_t;

  typedef struct packed {
    logic [5:0] lp_prev;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic irq;
    logic resume;
    logic [2:0] sync_stp;
  } ulpib_core_state_t;

  ulpib_link_state_t q, next_q;
  ulpib_core_state_t c, next_c;
  logic [7:0] regs [ulpib_pkg::reg_count];
  logic reg_we;

  function automatic logic agreed(input logic [2:0] s);
    agreed = s[1] & s[2];
  endfunction : agreed

  // link-clock domain: bus protocol decoder
  always_comb begin
    next_q = q;
    reg_we = 1'b0;
    next_q.sync_stp = {q.sync_stp[1:0], stp};
    next_q.sync_pll = {q.sync_pll[1:0], pll_ready};
    next_q.sync_txr = {q.sync_txr[1:0], tx_ready};
    next_q.sync_susp = {q.sync_susp[1:0], suspend};
    next_q.ls1 = line_state;
    next_q.ls2 = q.ls1;
    next_q.ls3 = q.ls2;
    next_q.rxv = rx_valid;
    next_q.rxd = rx_data;
    next_q.rxe = rx_end;
    next_q.nxt = 1'b0;
    next_q.txv = 1'b0;
    next_q.txl = 1'b0;
    case (q.st)
      ulpib_pkg::ulpib_startup: begin
        next_q.dir = 1'b1; // see [R5]
        next_q.oe = 1'b0;
        if (agreed(q.sync_pll) && q.cnt == ulpib_pkg::startup_cycles) begin
          next_q.dir = 1'b0; // see [R8]
          next_q.st = ulpib_pkg::ulpib_turn_back;
        end else if (agreed(q.sync_pll)) begin
          next_q.cnt = q.cnt + 8'h01;
        end
      end
      ulpib_pkg::ulpib_turn_back: begin
        next_q.oe = 1'b0; // see [R8]
        next_q.st = ulpib_pkg::ulpib_idle;
      end
      ulpib_pkg::ulpib_idle: begin
        next_q.oe = 1'b0;
        if (!agreed(q.sync_pll)) begin
          next_q.dir = 1'b1; // see [R5]
          next_q.cnt = 8'h00;
          next_q.st = ulpib_pkg::ulpib_startup;
        end else if (q.rxv) begin
          next_q.dir = 1'b1; // see [R3]
          next_q.st = ulpib_pkg::ulpib_rx;
        end else if (data_in != 8'h00) begin // see [R7] [R4]
          next_q.addr = data_in[5:0];
          case (data_in[7:6]) // see [R17]
            ulpib_pkg::cmd_transmit: begin
              next_q.nxt = agreed(q.sync_txr); // see [R11]
              next_q.cnt = 8'h00;
              next_q.st = ulpib_pkg::ulpib_tx;
            end
            ulpib_pkg::cmd_reg_write: begin
              next_q.nxt = 1'b1;
              next_q.cnt = 8'h00;
              next_q.st = ulpib_pkg::ulpib_reg_wdata;
            end
            ulpib_pkg::cmd_reg_read: begin
              next_q.nxt = 1'b1;
              next_q.st = ulpib_pkg::ulpib_rd_turn;
            end
            default: begin
              next_q.st = ulpib_pkg::ulpib_idle;
            end
          endcase
        end
      end
      ulpib_pkg::ulpib_tx: begin
        if (stp) begin // see [R9] [R10]
          next_q.txl = 1'b1;
          next_q.st = ulpib_pkg::ulpib_idle;
        end else begin
          next_q.nxt = agreed(q.sync_txr); // see [R11]
          // the first nxt acknowledges the command byte itself
          if (q.nxt) begin // see [R12]
            next_q.cnt = 8'h01;
            if (q.cnt != 8'h00) begin
              next_q.txd = data_in;
              next_q.txv = 1'b1;
            end
          end
        end
      end
      ulpib_pkg::ulpib_reg_wdata: begin
        if (stp) begin
          next_q.st = ulpib_pkg::ulpib_idle;
        end else if (q.nxt && q.cnt != 8'h00) begin
          reg_we = 1'b1; // see [R18]
          next_q.st = ulpib_pkg::ulpib_idle;
        end else if (q.nxt) begin
          // command taken; accept the data byte in the next cycle
          next_q.cnt = 8'h01;
          next_q.nxt = 1'b1;
        end
      end
      ulpib_pkg::ulpib_rd_turn: begin
        next_q.dir = 1'b1; // see [R3]
        next_q.oe = 1'b0; // see [R8] [R19]
        next_q.st = ulpib_pkg::ulpib_rd_data;
      end
      ulpib_pkg::ulpib_rd_data: begin
        if (!q.oe) begin
          next_q.oe = 1'b1;
          next_q.dout = regs[q.addr];
        end else begin
          next_q.oe = 1'b0;
          next_q.dir = 1'b0; // see [R8]
          next_q.st = ulpib_pkg::ulpib_turn_back;
        end
      end
      ulpib_pkg::ulpib_rx: begin
        if (!q.oe) begin
          next_q.oe = 1'b1; // see [R8]
          next_q.dout = q.rxd;
          next_q.nxt = q.rxv;
        end else if (q.rxe || !q.rxv) begin // see [R16]
          next_q.oe = 1'b0;
          next_q.dir = 1'b0;
          next_q.st = ulpib_pkg::ulpib_turn_back;
        end else begin
          next_q.dout = q.rxd; // see [R2]
          next_q.nxt = 1'b1;
        end
      end
      default: begin
        next_q.st = ulpib_pkg::ulpib_startup;
      end
    endcase
    // low power: hold the bus, drive line state after one turnaround
    if (agreed(q.sync_susp) && q.st != ulpib_pkg::ulpib_startup) begin
      reg_we = 1'b0;
      next_q.dir = 1'b1; // see [R14]
      next_q.oe = q.dir; // see [R8]
      next_q.nxt = 1'b0;
      next_q.txv = 1'b0;
      next_q.txl = 1'b0;
      if (q.ls2 == q.ls3) begin
        next_q.dout = {6'h00, q.ls3}; // see [R14]
      end
      // on wake the receive state drops dir with a turnaround
      next_q.st = ulpib_pkg::ulpib_rx;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin // see [R1]
    if (!reset_n) begin
      q <= '{st: ulpib_pkg::ulpib_startup, dir: 1'b1,
             default: '0};
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (reg_we) begin
      regs[q.addr] <= data_in; // see [R18]
    end
  end

  // core domain: low power interrupt and resume request
  always_comb begin
    next_c = c;
    next_c.sync_stp = {c.sync_stp[1:0], stp};
    next_c.s1 = {line_state, otg_comp, id_pin};
    next_c.s2 = c.s1;
    next_c.s3 = c.s2;
    next_c.irq = 1'b0;
    next_c.resume = 1'b0;
    if (suspend) begin
      if (c.s2 == c.s3) begin
        next_c.lp_prev = c.s3;
        next_c.irq = c.s3[3:0] != c.lp_prev[3:0]; // see [R15]
      end
      next_c.resume = agreed(c.sync_stp); // see [R13]
    end else begin
      next_c.lp_prev = c.s3;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign data_out = q.dout; // see [R14]
  assign data_oe = q.oe;
  assign dir = q.dir;
  assign nxt = q.nxt;
  assign tx_data = q.txd;
  assign tx_valid = q.txv;
  assign tx_last = q.txl;
  assign lp_interrupt = c.irq;
  assign resume_req = c.resume;

endmodule : ulpib_phy

// ==== hw/ulpib_pkg.sv ====
package ulpib_pkg;

  // link-side bus commands (top two bits of a link byte)
  localparam logic [1:0] cmd_special = 2'h0;
  localparam logic [1:0] cmd_transmit = 2'h1;
  localparam logic [1:0] cmd_reg_write = 2'h2;
  localparam logic [1:0] cmd_reg_read = 2'h3;

  localparam int reg_count = 64;
  localparam logic [7:0] reset_bus_out = 8'h00;
  localparam logic [5:0] reset_addr = 6'h00;
  localparam logic [7:0] reset_reg_value = 8'h00;

  // interface clock rate and receive end latency
  localparam int link_clock_mhz = 60;
  localparam int hs_clocks_per_link_clock = 8;
  localparam int receive_end_latency_hs = 43;
  localparam int receive_end_latency_max_hs = 63;
  localparam int receive_end_latency_cycles =
    receive_end_latency_hs / hs_clocks_per_link_clock;

  // power-up hold of the bus by the phy, in link clocks
  localparam logic [7:0] startup_cycles = 8'h10;

  typedef enum logic [2:0] {
    ulpib_startup = 3'b000,
    ulpib_idle = 3'b001,
    ulpib_tx = 3'b010,
    ulpib_reg_wdata = 3'b011,
    ulpib_rd_turn = 3'b100,
    ulpib_rd_data = 3'b101,
    ulpib_rx = 3'b110,
    ulpib_turn_back = 3'b111
  } ulpib_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic dir;
    logic nxt;
  } ulpib_link_out_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } ulpib_byte_t;

  typedef struct packed {
    logic [1:0] line_state;
    logic [2:0] otg_comp;
    logic id;
  } ulpib_lp_t;

endpackage : ulpib_pkg

// ==== verif/ulpi_phy_bus_interface_tb.sv ====
module ulpi_phy_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, link_clk = 0, reset_n = 0, pll_ready = 0, tx_ready = 1;
  logic rx_valid = 0, rx_end = 0, suspend = 0, id_pin = 0;
  logic [7:0] rx_data = 8'h00, rd;
  logic [1:0] line_state = 2'h0;
  logic [2:0] otg_comp = 3'h0;
  wire logic [7:0] data_out, tx_data, lbus, data_in;
  wire logic data_oe, dir, nxt, stp, tx_valid, tx_last, lp_interrupt;
  wire logic resume_req;
  int n_mismatch = 0, comparisons = 0, ntx = 0;
  always #5 mclk = ~mclk;
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end
  assign data_in = data_oe ? data_out : lbus;
  ulpib_phy i_ulpib_phy (.mclk, .reset_n, .link_clk, .data_in, .data_out,
    .data_oe, .dir, .nxt, .stp, .pll_ready, .tx_ready, .tx_data, .tx_valid,
    .tx_last, .rx_valid, .rx_data, .rx_end, .suspend, .line_state,
    .otg_comp, .id_pin, .lp_interrupt, .resume_req);
  ulpib_link_model i_ulpib_link_model (.link_clk, .dir, .nxt, .data_oe,
    .data_out, .bus(lbus), .stp);
  task check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge link_clk) begin
    if (tx_valid === 1'b1) begin
      check(tx_data, 8'h11 + 8'(ntx));
      ntx++;
    end
    if (tx_last === 1'b1) begin
      check(8'(ntx), 8'h03);
    end
  end
  task t_start;
    repeat (30) @(posedge link_clk);
    check({7'h00, dir}, 8'h01);
    @(negedge mclk) pll_ready = 1;
    for (int i = 0; i < 40 && dir !== 1'b0; i++) @(posedge link_clk);
    check({7'h00, dir}, 8'h00);
  endtask : t_start
  task t_tx_reg;
    i_ulpib_link_model.send(8'h41, 3);
    i_ulpib_link_model.send(8'h85, 1);
    i_ulpib_link_model.read(8'hc5, rd);
    check(rd, 8'h11);
    check(8'(ntx), 8'h03);
  endtask : t_tx_reg
  task t_rx;
    @(negedge link_clk) rx_valid = 1;
    rx_data = 8'h5a;
    for (int i = 0; i < 40 && !(nxt && dir); i++) @(posedge link_clk);
    check(data_out, 8'h5a);
    @(negedge link_clk) rx_valid = 0;
    rx_end = 1;
    @(negedge link_clk) rx_end = 0;
    for (int i = 0; i < 8 && dir !== 1'b0; i++) @(posedge link_clk);
    check({7'h00, dir}, 8'h00);
  endtask : t_rx
  task t_lp;
    @(negedge mclk) suspend = 1;
    line_state = 2'h2;
    repeat (8) @(posedge link_clk);
    check(data_out, 8'h02);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk) if (k == 0) id_pin = 1;
      else otg_comp = 3'h1;
      for (int i = 0; i < 20 && lp_interrupt !== 1'b1; i++) @(posedge mclk);
      check({7'h00, lp_interrupt}, 8'h01);
    end
    i_ulpib_link_model.hold_stp(1'b1);
    for (int i = 0; i < 20 && resume_req !== 1'b1; i++) @(posedge mclk);
    check({7'h00, resume_req}, 8'h01);
    i_ulpib_link_model.hold_stp(1'b0);
  endtask : t_lp
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (4) @(negedge link_clk);
    check({7'h00, dir}, 8'h01);
    reset_n = 1;
    t_start;
    t_tx_reg;
    t_rx;
    t_lp;
    end_of_test;
  end
endmodule : ulpi_phy_bus_interface_tb

// ==== verif/ulpib_link_model.sv ====
module ulpib_link_model (
  // phy side
  input wire logic link_clk,
  input wire logic dir,
  input wire logic nxt,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  // link drive
  output logic [7:0] bus,
  output logic stp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv = 8'h00;
  logic [7:0] rel = 8'hff;
  logic dq = 1'b1;
  initial stp = 1'b0;
  always @(posedge link_clk) begin
    dq <= dir;
    rel <= (dir || dq) ? ~rel : ~drv;
  end
  assign bus = (dir || dq) ? rel : drv;
  task automatic send(input logic [7:0] cmd, input int n);
    int i;
    int t;
    i = 0;
    t = 0;
    @(posedge link_clk) drv <= cmd;
    while (i <= n && t < 40) begin
      @(posedge link_clk) t++;
      if (nxt === 1'b1) i++;
      if (i > n) stp <= 1'b1;
      drv <= (i > n) ? 8'h00 : (i > 0 ? 8'h10 + 8'(i) : cmd);
    end
    @(posedge link_clk) stp <= 1'b0;
  endtask : send
  task automatic read(input logic [7:0] cmd, output logic [7:0] val);
    int t;
    @(posedge link_clk) drv <= cmd;
    for (t = 0; t < 40 && nxt !== 1'b1; t++) @(posedge link_clk);
    drv <= 8'h00;
    for (t = 0; t < 40 && data_oe !== 1'b1; t++) @(posedge link_clk);
    val = data_out;
  endtask : read
  task automatic hold_stp(input logic v);
    @(posedge link_clk) stp <= v;
  endtask : hold_stp
endmodule : ulpib_link_model

// ==== verif/ulpib_phy_properties.sv ====
module ulpib_phy_checker (
  // link side
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  // core side
  input wire logic pll_ready,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic suspend,
  input wire logic [1:0] line_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge link_clk); endclocking
  default disable iff (!reset_n);
  property p_oe; data_oe |-> dir; endproperty
  a_oe: assert property (p_oe) else $error("oe with dir low");
  property p_turn; $rose(dir) |-> !data_oe; endproperty
  a_turn: assert property (p_turn) else $error("no turnaround");
  property p_fall; $fell(dir) |=> !nxt; endproperty
  a_fall: assert property (p_fall) else $error("nxt in turnaround");
  property p_pll; (!pll_ready)[*4] |-> dir; endproperty
  a_pll: assert property (p_pll) else $error("dir low in start-up");
  property p_rx; $rose(rx_valid) |-> ##[1:4] dir; endproperty
  a_rx: assert property (p_rx) else $error("dir not raised");
  property p_end; $rose(rx_end) |-> ##[1:5] !dir; endproperty
  a_end: assert property (p_end) else $error("receive end late");
  property p_stp; stp && !dir |=> !nxt; endproperty
  a_stp: assert property (p_stp) else $error("nxt after stop");
  property p_lp;
    (suspend && $stable(line_state))[*6] |-> data_out == {6'h00, line_state};
  endproperty
  a_lp: assert property (p_lp) else $error("line state wrong");
  c_tx: cover property (nxt && !dir);
  c_rx: cover property (nxt && dir);
  c_lp: cover property (suspend && dir);
endmodule : ulpib_phy_checker

bind ulpib_phy ulpib_phy_checker i_ulpib_phy_checker (.link_clk, .reset_n,
  .data_out, .data_oe, .dir, .nxt, .stp, .pll_ready, .rx_valid, .rx_end,
  .suspend, .line_state);
